// file: smse_pkg.sv
// shared constants and types for the store-multiple / subtract / bit-test execution unit
package smse_pkg;
   localparam int DW = 16;
   localparam int AW = 24;
   localparam logic [AW-1:0] WORD_STEP = 24'h000002;
   localparam logic [3:0] R_PTR = 4'h1;
   localparam logic [3:0] R_PAIR_LO = 4'h6;
   localparam logic [3:0] R_PAIR_HI = 4'h7;
   localparam logic [3:0] R_DBL_LO = 4'h2;
   localparam int BYTE_W = 8;
   localparam logic [3:0] BYTE_OFS_MASK = 4'h7;

   typedef enum logic [3:0] {
      SMSE_OP_NOP,
      SMSE_OP_SUB_SIZED,
      SMSE_OP_SUB_DOUBLE,
      SMSE_OP_SUB_BORROW,
      SMSE_OP_XOR_SIZED,
      SMSE_OP_XOR_DOUBLE,
      SMSE_OP_TBIT,
      SMSE_OP_STORE_MULT,
      SMSE_OP_STORE_MULT_PAIR,
      SMSE_OP_STORE_DOUBLE,
      SMSE_OP_WAIT
   } smse_op_t;

   typedef enum {
      SMSE_ST_IDLE,
      SMSE_ST_STM,
      SMSE_ST_STD_HI,
      SMSE_ST_WAIT
   } smse_state_t;
endpackage

// file: smse_alu.sv
// combinational subtract / exclusive-or datapath with borrow and overflow
module smse_alu (
   // operands
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic cin,
   input wire logic [1:0] size,
   input wire logic do_xor,
   // results
   output logic [31:0] y,
   output logic borrow,
   output logic ovf
);
   logic [32:0] d;
   logic sa;
   logic sb;
   logic sy;
   always_comb begin
      d = {1'b0, a} - {1'b0, b} - {32'h00000000, cin};
      y = do_xor ? (a ^ b) : d[31:0];
      borrow = 1'b0;
      sa = a[31];
      sb = b[31];
      sy = d[31];
      case (size)
         2'h0: begin
            borrow = ({1'b0, a[7:0]} < ({1'b0, b[7:0]} + {8'h00, cin}));
            sa = a[7];
            sb = b[7];
            sy = d[7];
         end
         2'h1: begin
            borrow = ({1'b0, a[15:0]} < ({1'b0, b[15:0]} + {16'h0000, cin}));
            sa = a[15];
            sb = b[15];
            sy = d[15];
         end
         default: begin
            borrow = d[32];
         end
      endcase
      ovf = (sa != sb) && (sy != sa);
   end
endmodule

// file: smse_exec.sv
// execution unit: store multiple, double store, subtract, xor, bit test and wait
// Contract
// - store-multiple writes one to eight words
// - single-pointer start address from register 1
// - registers 2,3-5,8-11 to successive words
// - register 1 advances two per word
// - single-pointer address does not wrap at 64k
// - pair form starts at registers 7:6
// - pair address advances two per word
// - no interrupt during store-multiple
// - double store: low word first, high next
// - subtract destination minus source into destination
// - subtract sets carry on borrow, flag on overflow
// - subtract-with-borrow removes source plus carry
// - subtract-with-borrow updates carry and overflow
// - byte operations keep upper byte
// - bit test copies bit into overflow flag
// - offset 0-15 word, 0-7 byte
// - memory test byte/word, register word only
// - wait halts until interrupt
// - wait return address is next instruction
// - xor stores result, flags untouched
module smse_exec (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // instruction issue
   input wire logic op_valid,
   output logic op_ready,
   input wire smse_pkg::smse_op_t op_code,
   input wire logic [1:0] op_size,
   input wire logic [2:0] op_count,
   input wire logic op_mem_src,
   input wire logic [3:0] op_bit_offset,
   input wire logic [31:0] op_src,
   input wire logic [31:0] op_dest,
   input wire logic [23:0] op_addr,
   input wire logic [23:0] op_next_pc,
   // register file read port
   output logic [3:0] rf_rd_idx,
   input wire logic [15:0] rf_rd_data,
   input wire logic [15:0] rf_r1,
   input wire logic [15:0] rf_r6,
   input wire logic [15:0] rf_r7,
   // register file write port
   output logic rf_wr_en,
   output logic [3:0] rf_wr_idx,
   output logic [15:0] rf_wr_data,
   output logic rf_wr2_en,
   output logic [3:0] rf_wr2_idx,
   output logic [15:0] rf_wr2_data,
   output logic [31:0] dest_result,
   output logic dest_result_valid,
   // status flags
   output logic carry_flag,
   output logic overflow_flag,
   // data memory
   output logic mem_wr,
   output logic [23:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic mem_rdy,
   // interrupts
   input wire logic irq_pin,
   output logic irq_take,
   output logic [23:0] irq_return_pc,
   output logic waiting
);
   typedef struct packed {
      smse_pkg::smse_state_t st;
      logic [2:0] left;
      logic [2:0] seq;
      logic pair;
      logic [23:0] addr;
      logic [15:0] hi_word;
      logic [23:0] ret_pc;
      logic c;
      logic f;
      logic mem_wr;
      logic [23:0] mem_addr;
      logic [15:0] mem_wdata;
      logic wr_en;
      logic [3:0] wr_idx;
      logic [15:0] wr_data;
      logic wr2_en;
      logic [3:0] wr2_idx;
      logic [15:0] wr2_data;
      logic [31:0] res;
      logic res_v;
      logic take;
      logic [1:0] irq_sync;
   } smse_s_t;

   smse_s_t s_r;
   smse_s_t s_nxt;

   logic [31:0] alu_y;
   logic alu_b;
   logic alu_v;
   logic [31:0] alu_bop;
   logic alu_cin;
   logic alu_xor;

   // store-multiple register order: 2,3,4,5,8,9,10,11
   function automatic logic [3:0] smse_seq_reg(input logic [2:0] n);
      return (n < 3'h4) ? (smse_pkg::R_DBL_LO + {1'b0, n}) : ({1'b0, n} + 4'h4);
   endfunction

   // merge a sized result so a byte op keeps the upper byte
   function automatic logic [31:0] smse_merge(input logic [1:0] sz, input logic [31:0] old,
                                              input logic [31:0] nw);
      case (sz)
         2'h0: return {old[31:smse_pkg::BYTE_W], nw[smse_pkg::BYTE_W-1:0]};
         2'h1: return {old[31:smse_pkg::DW], nw[smse_pkg::DW-1:0]};
         default: return nw;
      endcase
   endfunction

   // double-word opcodes run the datapath at full width whatever the size field says
   function automatic logic [1:0] smse_eff_size(input smse_pkg::smse_op_t op,
                                                input logic [1:0] sz);
      return (op == smse_pkg::SMSE_OP_SUB_DOUBLE || op == smse_pkg::SMSE_OP_XOR_DOUBLE) ?
             2'h2 : sz;
   endfunction

   logic [1:0] eff_size;
   assign eff_size = smse_eff_size(op_code, op_size);

   assign alu_xor = (op_code == smse_pkg::SMSE_OP_XOR_SIZED) ||
                    (op_code == smse_pkg::SMSE_OP_XOR_DOUBLE);
   assign alu_cin = (op_code == smse_pkg::SMSE_OP_SUB_BORROW) ? s_r.c : 1'b0;
   assign alu_bop = op_src;

   smse_alu u_alu (
      .a(op_dest),
      .b(alu_bop),
      .cin(alu_cin),
      .size(eff_size),
      .do_xor(alu_xor),
      .y(alu_y),
      .borrow(alu_b),
      .ovf(alu_v)
   );

   // accept only while idle; a store beat still waiting for memory holds off the next one
   assign op_ready = (s_r.st == smse_pkg::SMSE_ST_IDLE) && !(s_r.mem_wr && !mem_rdy);

   always_comb begin
      logic [3:0] bofs;
      logic [15:0] wd;
      bofs = 4'h0;
      wd = 16'h0000;
      s_nxt = s_r;
      s_nxt.irq_sync = {s_r.irq_sync[0], irq_pin};
      s_nxt.mem_wr = 1'b0;
      s_nxt.wr_en = 1'b0;
      s_nxt.wr2_en = 1'b0;
      s_nxt.res_v = 1'b0;
      s_nxt.take = 1'b0;
      case (s_r.st)
         smse_pkg::SMSE_ST_IDLE: begin
            if (s_r.mem_wr && !mem_rdy) begin
               // last beat of a store stays on the bus until memory takes it
               s_nxt.mem_wr = 1'b1;
            end else if (op_valid) begin
               case (op_code)
                  smse_pkg::SMSE_OP_SUB_SIZED, smse_pkg::SMSE_OP_SUB_DOUBLE,
                  smse_pkg::SMSE_OP_SUB_BORROW: begin
                     s_nxt.res = smse_merge(eff_size, op_dest, alu_y);
                     s_nxt.res_v = 1'b1;
                     s_nxt.c = alu_b;
                     s_nxt.f = alu_v;
                  end
                  smse_pkg::SMSE_OP_XOR_SIZED, smse_pkg::SMSE_OP_XOR_DOUBLE: begin
                     // flags deliberately untouched
                     s_nxt.res = smse_merge(eff_size, op_dest, alu_y);
                     s_nxt.res_v = 1'b1;
                  end
                  smse_pkg::SMSE_OP_TBIT: begin
                     // register form is word only; byte offset masked to 0-7
                     bofs = (op_mem_src && op_size == 2'h0) ?
                            (op_bit_offset & smse_pkg::BYTE_OFS_MASK) : op_bit_offset;
                     s_nxt.f = op_src[bofs];
                  end
                  smse_pkg::SMSE_OP_STORE_MULT, smse_pkg::SMSE_OP_STORE_MULT_PAIR: begin
                     s_nxt.st = smse_pkg::SMSE_ST_STM;
                     s_nxt.left = op_count;
                     s_nxt.seq = 3'h0;
                     s_nxt.pair = (op_code == smse_pkg::SMSE_OP_STORE_MULT_PAIR);
                     // single pointer is widened, never wrapped at 64k
                     s_nxt.addr = s_nxt.pair ? {rf_r7[7:0], rf_r6} :
                                  {8'h00, rf_r1};
                  end
                  smse_pkg::SMSE_OP_STORE_DOUBLE: begin
                     s_nxt.mem_wr = 1'b1;
                     s_nxt.mem_addr = op_addr;
                     s_nxt.mem_wdata = op_src[15:0];
                     s_nxt.hi_word = op_src[31:16];
                     s_nxt.st = smse_pkg::SMSE_ST_STD_HI;
                  end
                  smse_pkg::SMSE_OP_WAIT: begin
                     s_nxt.ret_pc = op_next_pc;
                     s_nxt.st = smse_pkg::SMSE_ST_WAIT;
                  end
                  default: begin
                  end
               endcase
            end
         end
         smse_pkg::SMSE_ST_STM: begin
            // one word per memory-ready cycle; interrupts ignored here
            if (!s_r.mem_wr || mem_rdy) begin
               wd = rf_rd_data;
               s_nxt.mem_wr = 1'b1;
               s_nxt.mem_addr = s_r.addr;
               s_nxt.mem_wdata = wd;
               s_nxt.addr = s_r.addr + smse_pkg::WORD_STEP;
               s_nxt.seq = s_r.seq + 3'h1;
               if (s_r.pair) begin
                  s_nxt.wr_en = 1'b1;
                  s_nxt.wr_idx = smse_pkg::R_PAIR_LO;
                  s_nxt.wr_data = s_nxt.addr[15:0];
                  s_nxt.wr2_en = 1'b1;
                  s_nxt.wr2_idx = smse_pkg::R_PAIR_HI;
                  s_nxt.wr2_data = {8'h00, s_nxt.addr[23:16]};
               end else begin
                  s_nxt.wr_en = 1'b1;
                  s_nxt.wr_idx = smse_pkg::R_PTR;
                  s_nxt.wr_data = s_nxt.addr[15:0];
               end
               if (s_r.left == 3'h0) begin
                  s_nxt.st = smse_pkg::SMSE_ST_IDLE;
               end else begin
                  s_nxt.left = s_r.left - 3'h1;
               end
            end else begin
               s_nxt.mem_wr = 1'b1;
            end
         end
         smse_pkg::SMSE_ST_STD_HI: begin
            if (mem_rdy) begin
               s_nxt.mem_wr = 1'b1;
               s_nxt.mem_addr = s_r.mem_addr + smse_pkg::WORD_STEP;
               s_nxt.mem_wdata = s_r.hi_word;
               s_nxt.st = smse_pkg::SMSE_ST_IDLE;
            end else begin
               s_nxt.mem_wr = 1'b1;
            end
         end
         smse_pkg::SMSE_ST_WAIT: begin
            if (s_r.irq_sync[1]) begin
               s_nxt.take = 1'b1;
               s_nxt.st = smse_pkg::SMSE_ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = smse_pkg::SMSE_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rf_rd_idx = smse_seq_reg(s_r.seq);
   assign rf_wr_en = s_r.wr_en;
   assign rf_wr_idx = s_r.wr_idx;
   assign rf_wr_data = s_r.wr_data;
   assign rf_wr2_en = s_r.wr2_en;
   assign rf_wr2_idx = s_r.wr2_idx;
   assign rf_wr2_data = s_r.wr2_data;
   assign dest_result = s_r.res;
   assign dest_result_valid = s_r.res_v;
   assign carry_flag = s_r.c;
   assign overflow_flag = s_r.f;
   assign mem_wr = s_r.mem_wr;
   assign mem_addr = s_r.mem_addr;
   assign mem_wdata = s_r.mem_wdata;
   assign irq_take = s_r.take;
   assign irq_return_pc = s_r.ret_pc;
   assign waiting = (s_r.st == smse_pkg::SMSE_ST_WAIT);
endmodule

// file: smse_exec_asserts.sv
// concurrent checks on the execution unit ports
module smse_exec_asserts (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // instruction issue
   input wire logic op_valid,
   input wire logic op_ready,
   input wire smse_pkg::smse_op_t op_code,
   input wire logic [1:0] op_size,
   input wire logic [3:0] op_bit_offset,
   input wire logic [31:0] op_src,
   input wire logic [31:0] op_dest,
   // results and flags
   input wire logic [31:0] dest_result,
   input wire logic carry_flag,
   input wire logic overflow_flag,
   // memory and interrupts
   input wire logic mem_wr,
   input wire logic [23:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic mem_rdy,
   input wire logic irq_pin,
   input wire logic irq_take,
   input wire logic waiting
);
   timeunit 1ns;
   timeprecision 1ns;
   logic bit_r;
   logic [23:0] hi_r;
   logic take;
   assign take = op_valid && op_ready;
   // operand samples kept one cycle so results can be tied to their cause
   always_ff @(posedge clk_sys) begin
      bit_r <= op_src[op_bit_offset];
      hi_r <= op_dest[31:8];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_beat_then_wr;
      mem_wr && mem_rdy && !op_ready ##1 mem_wr;
   endsequence
   a_store_blocks_issue: assert property (mem_wr && !mem_rdy |-> !op_ready)
      else $error("issue open during store");
   a_no_irq_store: assert property (mem_wr |-> !irq_take)
      else $error("interrupt taken during store");
   a_write_holds: assert property (mem_wr && !mem_rdy |=> mem_wr && $stable(mem_addr)
      && $stable(mem_wdata))
      else $error("store changed before accept");
   a_addr_step: assert property (s_beat_then_wr |-> mem_addr == $past(mem_addr) + 24'h000002)
      else $error("store address step wrong");
   a_wait_wakes: assert property (waiting && $rose(irq_pin) |-> ##[1:4] irq_take)
      else $error("wait not ended by interrupt");
   a_take_in_wait: assert property (irq_take |-> $past(waiting))
      else $error("interrupt taken outside wait");
   a_xor_keeps_flags: assert property (take && op_code inside {smse_pkg::SMSE_OP_XOR_SIZED,
      smse_pkg::SMSE_OP_XOR_DOUBLE} |=> $stable(carry_flag) && $stable(overflow_flag))
      else $error("xor changed flags");
   a_tbit_copy: assert property (take && op_code == smse_pkg::SMSE_OP_TBIT && op_size == 2'h1
      |=> overflow_flag == bit_r)
      else $error("bit test flag wrong");
   a_byte_upper: assert property (take && op_size == 2'h0 && op_code inside
      {smse_pkg::SMSE_OP_SUB_SIZED, smse_pkg::SMSE_OP_SUB_BORROW, smse_pkg::SMSE_OP_XOR_SIZED}
      |=> dest_result[31:8] == hi_r)
      else $error("byte op touched upper bits");
endmodule
bind smse_exec smse_exec_asserts smse_exec_asserts_inst (.*);

// file: smse_mem_model.sv
// data memory model: accepts writes at full rate or stalled, logs each accepted word
module smse_mem_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // write port
   input wire logic mem_wr,
   input wire logic [23:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_rdy,
   // stall control
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tick;
   logic [23:0] log_a[$];
   logic [15:0] log_d[$];
   // stalled mode accepts every other cycle so the store must hold its beat
   assign mem_rdy = mem_wr && (!slow || tick);
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tick <= 1'b0;
      end else begin
         tick <= !tick;
         if (mem_wr && mem_rdy) begin
            log_a.push_back(mem_addr);
            log_d.push_back(mem_wdata);
         end
      end
   end
endmodule

// file: test_store_multiple_sub_tbit_exec.sv
// self-checking bench for the execution unit
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_store_multiple_sub_tbit_exec;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [3:0] op; logic [1:0] sz; logic [3:0] ofs; logic [31:0] s;
      logic [31:0] d; logic [31:0] r; logic c; logic f;} smse_row_t;
   logic clk_sys = 0, nrst = 0, op_valid = 0, op_mem_src = 0, irq_pin = 0, slow = 0;
   smse_pkg::smse_op_t op_code = smse_pkg::SMSE_OP_NOP;
   logic [1:0] op_size = 0;
   logic [2:0] op_count = 0;
   logic [3:0] op_bit_offset = 0, rf_rd_idx, rf_wr_idx, rf_wr2_idx;
   logic [31:0] op_src = 0, op_dest = 0, dest_result;
   logic [23:0] op_addr = 0, op_next_pc = 0, mem_addr, irq_return_pc;
   logic [15:0] rf[16], rf_rd_data, rf_r1, rf_r6, rf_r7, rf_wr_data, rf_wr2_data, mem_wdata;
   logic op_ready, rf_wr_en, rf_wr2_en, dest_result_valid, carry_flag, overflow_flag;
   logic mem_wr, mem_rdy, irq_take, waiting;
   int n_tests = 0, miscompares = 0;
   int order[8] = '{2, 3, 4, 5, 8, 9, 10, 11};
   // ops: 1 sub, 2 sub double, 3 sub borrow, 4 xor, 5 xor double, 6 bit test
   smse_row_t rows[11] = '{
      '{4'h1, 2'h0, 4'h0, 32'h01, 32'h0000AA7F, 32'h0000AA7E, 1'b0, 1'b0},
      '{4'h1, 2'h1, 4'h0, 32'h01, 32'h00008000, 32'h00007FFF, 1'b0, 1'b1},
      '{4'h2, 2'h2, 4'h0, 32'h01, 32'h00000000, 32'hFFFFFFFF, 1'b1, 1'b0},
      '{4'h3, 2'h0, 4'h0, 32'h20, 32'h0000BB50, 32'h0000BB2F, 1'b0, 1'b0},
      '{4'h3, 2'h1, 4'h0, 32'h01, 32'h00000000, 32'h0000FFFF, 1'b1, 1'b0},
      '{4'h3, 2'h1, 4'h0, 32'h00, 32'h00008000, 32'h00007FFF, 1'b0, 1'b1},
      '{4'h4, 2'h0, 4'h0, 32'hF0, 32'h0000CC95, 32'h0000CC65, 1'b0, 1'b1},
      '{4'h5, 2'h2, 4'h0, 32'hFFFF0000, 32'h12345678, 32'hEDCB5678, 1'b0, 1'b1},
      '{4'h6, 2'h1, 4'h3, 32'h0008, 32'h0008, 32'h0, 1'b0, 1'b1},
      '{4'h6, 2'h1, 4'hF, 32'h7FFF, 32'h7FFF, 32'h0, 1'b0, 1'b0},
      '{4'h6, 2'h0, 4'h7, 32'h0080, 32'h0080, 32'h0, 1'b0, 1'b1}};
   assign rf_rd_data = rf[rf_rd_idx];
   assign rf_r1 = rf[1];
   assign rf_r6 = rf[6];
   assign rf_r7 = rf[7];
   smse_exec smse_exec_inst (.*);
   smse_mem_model smse_mem_model_inst (.*);
   initial begin
      forever #50 clk_sys = !clk_sys;
   end
   // register file stands in for the decoder side and takes pointer writebacks
   always @(posedge clk_sys) begin
      if (rf_wr_en === 1'b1) rf[rf_wr_idx] <= rf_wr_data;
      if (rf_wr2_en === 1'b1) rf[rf_wr2_idx] <= rf_wr2_data;
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 200 && op_ready !== 1'b1; k++) @(posedge clk_sys) #1;
   endtask
   task automatic issue(input logic [3:0] op, input logic [1:0] sz, input logic [3:0] ofs,
         input logic [31:0] s, input logic [31:0] d);
      wait_idle();
      // one edge between requests so op_valid is never lowered and raised in one step
      @(posedge clk_sys) #1;
      op_code = smse_pkg::smse_op_t'(op);
      op_size = sz;
      op_bit_offset = ofs;
      op_mem_src = (sz == 2'h0);
      op_src = s;
      op_dest = d;
      op_valid = 1'b1;
      @(posedge clk_sys) #1;
      op_valid = 1'b0;
   endtask
   task automatic chk_wr(input logic [23:0] a, input logic [15:0] d);
      logic [23:0] ga;
      logic [15:0] gd;
      ga = smse_mem_model_inst.log_a.pop_front();
      gd = smse_mem_model_inst.log_d.pop_front();
      `CHK("store addr", a, ga)
      `CHK("store data", d, gd)
   endtask
   initial begin
      #(3000 * 100);
      miscompares++;
      finish_test();
   end
   initial begin
      for (int i = 0; i < 16; i++) rf[i] = 16'h1100 + 16'(i);
      rf[1] = 16'hFFFC;
      repeat (2) @(posedge clk_sys);
      #1 nrst = 1'b1;
      `CHK("ready after reset", 1'b1, op_ready)
      foreach (rows[i]) begin
         issue(rows[i].op, rows[i].sz, rows[i].ofs, rows[i].s, rows[i].d);
         if (rows[i].op == 4'h6) begin
            @(posedge clk_sys) #1;
         end else begin
            for (int k = 0; k < 3 && dest_result_valid !== 1'b1; k++) @(posedge clk_sys) #1;
            `CHK("result valid", 1'b1, dest_result_valid)
            `CHK("result", rows[i].r, dest_result)
         end
         `CHK("carry", rows[i].c, carry_flag)
         `CHK("overflow", rows[i].f, overflow_flag)
      end
      // eight words across the 64k line, stalled memory, interrupt pending
      slow = 1'b1;
      irq_pin = 1'b1;
      op_count = 3'h7;
      issue(4'h7, 2'h1, 4'h0, 32'h0, 32'h0);
      wait_idle();
      repeat (2) @(posedge clk_sys) #1;
      irq_pin = 1'b0;
      `CHK("no take in store", 1'b0, irq_take)
      `CHK("word count", 8, smse_mem_model_inst.log_a.size())
      foreach (order[j]) chk_wr(24'h00FFFC + 24'(2 * j), 16'h1100 + 16'(order[j]));
      `CHK("pointer", 16'h000C, rf[1])
      rf[6] = 16'hFFFE;
      rf[7] = 16'h0012;
      op_count = 3'h0;
      issue(4'h8, 2'h1, 4'h0, 32'h0, 32'h0);
      wait_idle();
      repeat (2) @(posedge clk_sys) #1;
      chk_wr(24'h12FFFE, 16'h1102);
      `CHK("pair count", 0, smse_mem_model_inst.log_a.size())
      `CHK("pair low", 16'h0000, rf[6])
      `CHK("pair high", 16'h0013, rf[7])
      slow = 1'b0;
      op_addr = 24'h009120;
      issue(4'h9, 2'h2, 4'h0, 32'h12345678, 32'h0);
      wait_idle();
      repeat (2) @(posedge clk_sys) #1;
      chk_wr(24'h009120, 16'h5678);
      chk_wr(24'h009122, 16'h1234);
      op_next_pc = 24'h001234;
      issue(4'hA, 2'h1, 4'h0, 32'h0, 32'h0);
      repeat (4) @(posedge clk_sys) #1;
      `CHK("waiting", 1'b1, waiting)
      irq_pin = 1'b1;
      for (int k = 0; k < 8 && irq_take !== 1'b1; k++) @(posedge clk_sys) #1;
      `CHK("wake", 1'b1, irq_take)
      `CHK("return pc", 24'h001234, irq_return_pc)
      irq_pin = 1'b0;
      finish_test();
   end
endmodule
